// [include/asenc_pkg.sv]
// Package with constants and types for the angle sensor serial and encoder block
package asenc_pkg;

    // Opcodes and frame layout
    localparam logic [3:0] OP_READ      = 4'h1;
    localparam logic [3:0] OP_WRITE     = 4'h2;
    localparam int         FRAME_BITS   = 16;
    localparam int         INDEX_BITS   = 24;

    // Register addresses
    localparam logic [3:0] ADDR_ZOFS_HI = 4'h4;
    localparam logic [3:0] ADDR_ZOFS_LO = 4'h5;
    localparam logic [3:0] ADDR_FUSE    = 4'h9;
    localparam logic [7:0] REG_RESET    = 8'h00;

    // Refresh timing
    localparam int         REFRESH_NS   = 2000;
    localparam int         CLK_NS       = 25;
    localparam int         REFRESH_CYC  = REFRESH_NS / CLK_NS;

    // Serial frame states
    typedef enum logic [2:0] {
        ASENC_IDLE  = 3'b001,
        ASENC_SHIFT = 3'b010,
        ASENC_DONE  = 3'b100
    } asenc_state_t;

    // Encoder outputs carried together
    typedef struct packed {
        logic a;
        logic b;
        logic z;
    } asenc_quad_t;

    typedef struct packed {
        logic u;
        logic v;
        logic w;
    } asenc_comm_t;

endpackage

// [design/asenc_top.sv]
// Serial slave, register file, fuse store and encoder outputs of the angle sensor
`timescale 1ns/1ps
`default_nettype none

module asenc_top
    import asenc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [15:0] raw_angle_i,
    input  wire logic        cs_n_i,
    input  wire logic        sclk_i,
    input  wire logic        mosi_i,
    output logic             miso_o,
    output asenc_quad_t      quadrature_outputs_o,
    output asenc_comm_t      commutation_outputs_o,
    output logic             fuse_burn_o,
    output logic [3:0]       fuse_burn_addr_o,
    output logic [7:0]       fuse_burn_data_o
);

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    // Three stages; a change counts once stages two and three agree
    logic [2:0] cs_sync;
    logic [2:0] sck_sync;
    logic [2:0] mosi_sync;
    logic       cs_lvl;
    logic       sck_lvl;
    logic       next_cs_lvl;
    logic       next_sck_lvl;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cs_sync   <= 3'h7;
            sck_sync  <= 3'h0;
            mosi_sync <= 3'h0;
        end
        else
        begin
            cs_sync   <= {cs_sync[1:0], cs_n_i};
            sck_sync  <= {sck_sync[1:0], sclk_i};
            mosi_sync <= {mosi_sync[1:0], mosi_i};
        end
    end

    // Filtered levels only move when the last two stages agree
    always_comb
    begin
        next_cs_lvl  = (cs_sync[1] == cs_sync[2]) ? cs_sync[2] : cs_lvl;
        next_sck_lvl = (sck_sync[1] == sck_sync[2]) ? sck_sync[2] : sck_lvl;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cs_lvl  <= 1'b1;
            sck_lvl <= 1'b0;
        end
        else
        begin
            cs_lvl  <= next_cs_lvl;
            sck_lvl <= next_sck_lvl;
        end
    end

    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    assign cs_fall  = cs_lvl && !next_cs_lvl;
    assign cs_rise  = !cs_lvl && next_cs_lvl;
    assign sck_rise = !sck_lvl && next_sck_lvl && !cs_lvl;
    assign sck_fall = sck_lvl && !next_sck_lvl && !cs_lvl;

    // ********************************************************
    // Registers, fuses and angle
    // ********************************************************
    logic [7:0]  zofs_hi;
    logic [7:0]  zofs_lo;
    logic [7:0]  fuse_sel;
    logic [7:0]  fuse_hi;
    logic [7:0]  fuse_lo;
    logic [1:0]  burned;
    logic [15:0] angle;
    logic [11:0] zofs;

    assign zofs  = {zofs_hi, zofs_lo[3:0]};
    assign angle = raw_angle_i - {zofs, 4'h0};

    // ********************************************************
    // Output buffer and index
    // ********************************************************
    // Refresh is held off while a frame runs, so a frame never tears
    logic [6:0]  ref_cnt;
    logic [6:0]  next_ref_cnt;
    logic [15:0] buf_angle;
    logic [15:0] next_buf_angle;
    logic [7:0]  buf_index;
    logic [7:0]  next_buf_index;

    always_comb
    begin
        next_ref_cnt   = ref_cnt + 7'h01;
        next_buf_angle = buf_angle;
        next_buf_index = buf_index;
        if (ref_cnt == 7'(REFRESH_CYC - 1))
        begin
            next_ref_cnt = 7'h00;
            if (cs_lvl)
            begin
                next_buf_angle = angle;
                next_buf_index = buf_index + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ref_cnt   <= 7'h00;
            buf_angle <= 16'h0000;
            buf_index <= 8'h00;
        end
        else
        begin
            ref_cnt   <= next_ref_cnt;
            buf_angle <= next_buf_angle;
            buf_index <= next_buf_index;
        end
    end

    // ********************************************************
    // Serial frame engine
    // ********************************************************
    asenc_state_t state;
    asenc_state_t next_state;
    logic [4:0]   bit_cnt;
    logic [4:0]   next_bit_cnt;
    logic [15:0]  rx;
    logic [15:0]  next_rx;
    logic [23:0]  tx;
    logic [23:0]  next_tx;
    logic         miso;
    logic         next_miso;
    logic [7:0]   next_zofs_hi;
    logic [7:0]   next_zofs_lo;
    logic [7:0]   next_fuse_sel;
    logic [7:0]   rd_val;
    logic [15:0]  cmd;

    // Register read mux; unmapped addresses read zero
    always_comb
    begin
        unique case (rx[2:0] == 3'h0 ? 4'h0 : {rx[2:0], mosi_sync[2]})
            ADDR_ZOFS_HI: rd_val = zofs_hi;
            ADDR_ZOFS_LO: rd_val = zofs_lo;
            ADDR_FUSE:    rd_val = fuse_sel;
            default:      rd_val = 8'h00;
        endcase
    end

    assign cmd = {rx[14:0], mosi_sync[2]};

    always_comb
    begin
        next_state    = state;
        next_bit_cnt  = bit_cnt;
        next_rx       = rx;
        next_tx       = tx;
        next_miso     = miso;
        next_zofs_hi  = zofs_hi;
        next_zofs_lo  = zofs_lo;
        next_fuse_sel = fuse_sel;
        unique case (state)
            ASENC_IDLE:
            begin
                if (cs_fall)
                begin
                    next_state   = ASENC_SHIFT;
                    next_bit_cnt = 5'h00;
                    next_tx      = {buf_angle, buf_index};
                    next_miso    = buf_angle[15];
                end
            end
            ASENC_SHIFT:
            begin
                if (sck_rise)
                begin
                    next_rx      = cmd;
                    next_bit_cnt = bit_cnt + 5'h01;
                    // Read reply replaces the angle low byte, which has moved up seven places by now
                    if (bit_cnt == 5'h07 && cmd[7:4] == OP_READ)
                        next_tx[22:15] = rd_val;
                    if (bit_cnt == 5'(FRAME_BITS - 1) && cmd[15:12] == OP_WRITE)
                    begin
                        unique case (cmd[11:8])
                            ADDR_ZOFS_HI: if (!burned[0]) next_zofs_hi = cmd[7:0];
                            ADDR_ZOFS_LO: if (!burned[1]) next_zofs_lo = cmd[7:0];
                            ADDR_FUSE:    next_fuse_sel = cmd[7:0];
                            default:      next_fuse_sel = fuse_sel;
                        endcase
                    end
                end
                if (sck_fall)
                begin
                    next_tx   = {tx[22:0], 1'b0};
                    next_miso = tx[22];
                end
                if (cs_rise)
                    next_state = ASENC_DONE;
            end
            ASENC_DONE:
            begin
                next_state = ASENC_IDLE;
                next_miso  = 1'b0;
            end
            default:
                next_state = ASENC_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state   <= ASENC_IDLE;
            bit_cnt <= 5'h00;
            rx      <= 16'h0000;
            tx      <= 24'h000000;
            miso    <= 1'b0;
        end
        else
        begin
            state   <= next_state;
            bit_cnt <= next_bit_cnt;
            rx      <= next_rx;
            tx      <= next_tx;
            miso    <= next_miso;
        end
    end

    // ********************************************************
    // Fuse store
    // ********************************************************
    // Fuses model the non-volatile cells; they survive rst_n_i, which stands for a power cycle
    logic [1:0] next_burned;
    logic [7:0] next_fuse_hi;
    logic [7:0] next_fuse_lo;
    logic       burn;
    logic       next_burn;
    logic       loaded;

    always_comb
    begin
        next_burned  = burned;
        next_fuse_hi = fuse_hi;
        next_fuse_lo = fuse_lo;
        next_burn    = 1'b0;
        if (fuse_sel[ADDR_ZOFS_HI[2:0]] && !burned[0])
        begin
            next_burned[0] = 1'b1;
            next_fuse_hi   = zofs_hi;
            next_burn      = 1'b1;
        end
        else if (fuse_sel[ADDR_ZOFS_LO[2:0]] && !burned[1])
        begin
            next_burned[1] = 1'b1;
            next_fuse_lo   = zofs_lo;
            next_burn      = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        burned  <= (burned === 2'bxx) ? 2'b00 : next_burned;
        fuse_hi <= next_fuse_hi;
        fuse_lo <= next_fuse_lo;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            burn   <= 1'b0;
            loaded <= 1'b0;
        end
        else
        begin
            burn   <= next_burn;
            loaded <= 1'b1;
        end
    end

    // Registers clear at reset; burned ones are reloaded on the first edge after release
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            zofs_hi  <= REG_RESET;
            zofs_lo  <= REG_RESET;
            fuse_sel <= REG_RESET;
        end
        else if (!loaded)
        begin
            zofs_hi  <= burned[0] ? fuse_hi : REG_RESET;
            zofs_lo  <= burned[1] ? fuse_lo : REG_RESET;
            fuse_sel <= REG_RESET;
        end
        else
        begin
            zofs_hi  <= next_zofs_hi;
            zofs_lo  <= next_zofs_lo;
            fuse_sel <= next_fuse_sel;
        end
    end

    // ********************************************************
    // Encoder outputs
    // ********************************************************
    // Angle bits 7:6 form the quadrature state; A leads, so B follows a quarter behind
    asenc_quad_t quad;
    asenc_comm_t comm;
    logic [15:0] comm_ph;

    always_comb
    begin
        quad.a  = angle[7] ^ angle[6];
        quad.b  = angle[7];
        quad.z  = (angle[15:6] == 10'h000);
        comm_ph = angle;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            quadrature_outputs_o  <= '0;
            commutation_outputs_o <= '0;
        end
        else
        begin
            quadrature_outputs_o <= quad;
            // Half-turn squares offset by one sixth turn each
            commutation_outputs_o.u <= comm_ph < 16'h8000;
            commutation_outputs_o.v <= 16'(comm_ph - 16'h2aab) < 16'h8000;
            commutation_outputs_o.w <= 16'(comm_ph - 16'h5555) < 16'h8000;
        end
    end

    assign miso_o           = miso;
    assign fuse_burn_o      = burn;
    assign fuse_burn_addr_o = burned[1] ? ADDR_ZOFS_LO : ADDR_ZOFS_HI;
    assign fuse_burn_data_o = burned[1] ? fuse_lo : fuse_hi;

endmodule

`default_nettype wire

// [test/asenc_spi_master.sv]
// SPI master model standing on the far side of the sensor's serial port
`timescale 1ns/1ps
`default_nettype none

module asenc_spi_master
(
    input  wire logic clk_i,
    input  wire logic miso_i,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      mosi_o
);
    // ****************
    // Frame driver
    // ****************
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end

    // Shifts n bits of tx MSB first at 5 MHz; sclk rests low between frames
    task automatic xfer(input int n, input logic [23:0] tx, output logic [23:0] rx);
        rx = 24'h0;
        @(negedge clk_i);
        cs_n_o = 1'b0;
        mosi_o = tx[23];
        repeat (8) @(negedge clk_i);
        for (int i = 0; i < n; i++)
        begin
            sclk_o = 1'b1;
            rx[23 - i] = miso_i;
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b0;
            mosi_o = (i < 23) ? tx[22 - i] : ~mosi_o;
            repeat (4) @(negedge clk_i);
        end
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o; // Released line must not keep showing the last bit
        repeat (8) @(negedge clk_i);
    endtask
endmodule

`default_nettype wire

// [test/asenc_assertions.sv]
// Concurrent checks on the ports of the sensor block
`timescale 1ns/1ps
`default_nettype none

module asenc_chk
    import asenc_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic [15:0] raw_angle_i,
    input wire logic        cs_n_i,
    input wire logic        sclk_i,
    input wire logic        mosi_i,
    input wire logic        miso_o,
    input wire asenc_quad_t quadrature_outputs_o,
    input wire asenc_comm_t commutation_outputs_o,
    input wire logic        fuse_burn_o,
    input wire logic [3:0]  fuse_burn_addr_o,
    input wire logic [7:0]  fuse_burn_data_o
);
    // ****************
    // Helper counters
    // ****************
    logic [3:0]  pin_quiet;
    logic [3:0]  next_pin_quiet;
    logic [8:0]  raw_quiet;
    logic [8:0]  next_raw_quiet;
    logic        cs_q;
    logic        sclk_q;
    logic [15:0] raw_q;

    // Cycles since a pin or angle change; saturating so a long idle never wraps into range
    always_comb
    begin
        next_pin_quiet = (cs_n_i != cs_q || sclk_i != sclk_q) ? 4'h0 : pin_quiet + {3'h0, pin_quiet != 4'hf};
        next_raw_quiet = (raw_angle_i != raw_q) ? 9'h0 : raw_quiet + {8'h0, raw_quiet != 9'h1ff};
    end

    // Raw count starts at zero so the reload right after reset has a cause
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pin_quiet <= 4'hf;
            raw_quiet <= 9'h0;
            cs_q      <= 1'b1;
            sclk_q    <= 1'b0;
            raw_q     <= 16'h0;
        end
        else
        begin
            pin_quiet <= next_pin_quiet;
            raw_quiet <= next_raw_quiet;
            cs_q      <= cs_n_i;
            sclk_q    <= sclk_i;
            raw_q     <= raw_angle_i;
        end
    end

    // ****************
    // Properties
    // ****************
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_burn_pulse; fuse_burn_o |=> !fuse_burn_o [*8]; endproperty
    a_burn_pulse: assert property (p_burn_pulse) else $error("burn pulse repeated");
    property p_burn_addr; fuse_burn_o |-> fuse_burn_addr_o == 4'h4 || fuse_burn_addr_o == 4'h5; endproperty
    a_burn_addr: assert property (p_burn_addr) else $error("burn of a register without fuses");
    property p_burn_hold; $changed(fuse_burn_addr_o) || $changed(fuse_burn_data_o) |-> fuse_burn_o; endproperty
    a_burn_hold: assert property (p_burn_hold) else $error("burn record moved without a burn");
    property p_burn_cause; fuse_burn_o |-> pin_quiet < 4'h8; endproperty
    a_burn_cause: assert property (p_burn_cause) else $error("burn not tied to a frame");
    property p_zero_ab; quadrature_outputs_o.z |-> !quadrature_outputs_o.a && !quadrature_outputs_o.b; endproperty
    a_zero_ab: assert property (p_zero_ab) else $error("index pulse away from zero");
    property p_reset_out; $rose(rst_n_i) |-> !fuse_burn_o && !miso_o; endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");
    property p_miso_cause; $changed(miso_o) |-> pin_quiet < 4'h8; endproperty
    a_miso_cause: assert property (p_miso_cause) else $error("serial out moved without a pin edge");
    property p_enc_cause;
        $changed(quadrature_outputs_o) || $changed(commutation_outputs_o) |-> raw_quiet < 9'h190 || pin_quiet < 4'h8;
    endproperty
    a_enc_cause: assert property (p_enc_cause) else $error("encoder outputs moved without cause");

    c_burn: cover property (fuse_burn_o);
    c_zero: cover property (quadrature_outputs_o.z);
    c_frame: cover property ($fell(cs_n_i));
endmodule

bind asenc_top asenc_chk u_asenc_chk (.clk_i, .rst_n_i, .raw_angle_i, .cs_n_i, .sclk_i, .mosi_i, .miso_o,
    .quadrature_outputs_o, .commutation_outputs_o, .fuse_burn_o, .fuse_burn_addr_o, .fuse_burn_data_o);

`default_nettype wire

// [test/test_angle_sensor_serial_and_encoder_outputs.sv]
// Self-checking bench for the sensor's serial, fuse and encoder outputs
`timescale 1ns/1ps
`default_nettype none

module test_angle_sensor_serial_and_encoder_outputs
    import asenc_pkg::*;
;
    // ****************
    // Signals and instances
    // ****************
    logic        clk   = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] raw   = 16'h0;
    logic        cs_n;
    logic        sclk;
    logic        mosi;
    logic        miso;
    asenc_quad_t quad;
    asenc_comm_t comm;
    logic        burn;
    logic [3:0]  baddr;
    logic [7:0]  bdata;
    logic [23:0] rx;
    logic [15:0] e;
    logic [7:0]  i1;
    logic [11:0] zofs = 12'h0;
    logic [15:0] qv [5] = '{16'h0000, 16'h0040, 16'h0080, 16'h00c0, 16'h8020};
    int          miscompares = 0;
    int          check_count = 0;
    int          burns = 0;

    always #12.5 clk = ~clk;

    asenc_top u_asenc_top (.clk_i(clk), .rst_n_i(rst_n), .raw_angle_i(raw), .cs_n_i(cs_n), .sclk_i(sclk),
        .mosi_i(mosi), .miso_o(miso), .quadrature_outputs_o(quad), .commutation_outputs_o(comm),
        .fuse_burn_o(burn), .fuse_burn_addr_o(baddr), .fuse_burn_data_o(bdata));
    asenc_spi_master u_asenc_spi_master (.clk_i(clk), .miso_i(miso), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi));

    // The burn pulse stands one cycle, so every rising edge must look
    always @(posedge clk) if (burn === 1'b1) burns++;

    // ****************
    // Shared tasks
    // ****************
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic logic [15:0] ang();
        return raw - {zofs, 4'h0};
    endfunction

    // Waits past one refresh period so the buffer holds the new angle
    task automatic setraw(input logic [15:0] v);
        @(negedge clk);
        raw = v;
        repeat (100) @(negedge clk);
        e = ang();
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        u_asenc_spi_master.xfer(16, {OP_READ, a, 16'h0}, rx);
        check("angle byte", {16'h0, rx[23:16]}, {16'h0, e[15:8]});
        check("register", {16'h0, rx[15:8]}, {16'h0, exp});
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        u_asenc_spi_master.xfer(16, {OP_WRITE, a, v, 8'h0}, rx);
    endtask

    task automatic rang(input int n);
        u_asenc_spi_master.xfer(n, 24'h0, rx);
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_regs();
        setraw(16'hb7c4);
        rd(ADDR_ZOFS_HI, 8'h00);
        rd(ADDR_ZOFS_LO, 8'h00);
        rd(ADDR_FUSE, 8'h00);
        rd(4'h3, 8'h00);
    endtask

    task automatic t_offset();
        wr(ADDR_ZOFS_HI, 8'h23);
        wr(ADDR_ZOFS_LO, 8'h08);
        zofs = 12'h238;
        setraw(raw);
        rd(ADDR_ZOFS_HI, 8'h23);
        rd(ADDR_ZOFS_LO, 8'h08);
        rang(16);
        check("angle", {8'h0, rx[23:8]}, {8'h0, e});
        foreach (qv[i])
        begin
            setraw(qv[i] + {zofs, 4'h0});
            check("quad", {21'h0, quad}, {21'h0, qv[i][7] ^ qv[i][6], qv[i][7], qv[i][15:6] == 10'h0});
        end
        // U high in the first half turn, V and W the same one and two sixths later
        setraw(16'h4000 + {zofs, 4'h0});
        check("comm quarter", {21'h0, comm}, 24'h000006);
        setraw(16'h9000 + {zofs, 4'h0});
        check("comm past half", {21'h0, comm}, 24'h000003);
    endtask

    task automatic t_short();
        setraw(16'h5a3c);
        rang(8);
        check("coarse", {16'h0, rx[23:16]}, {16'h0, e[15:8]});
        u_asenc_spi_master.xfer(12, {OP_WRITE, ADDR_ZOFS_HI, 16'hff00}, rx);
        rd(ADDR_ZOFS_HI, 8'h23);
    endtask

    task automatic t_index();
        rang(24);
        check("angle of index read", {8'h0, rx[23:8]}, {8'h0, e});
        i1 = rx[7:0];
        rang(24);
        check("repeat read", {8'h0, rx[23:8]}, {8'h0, e});
        repeat (400) @(negedge clk);
        rang(24);
        check("index step", {23'h0, (rx[7:0] - i1 - 8'h4) <= 8'h4}, 24'h1);
    endtask

    task automatic t_freeze();
        setraw(16'h4321);
        fork
            rang(16);
            begin
                repeat (30) @(negedge clk);
                raw = 16'h9abc;
            end
        join
        check("frozen", {8'h0, rx[23:8]}, {8'h0, e});
        setraw(16'h9abc);
        rang(16);
        check("refreshed", {8'h0, rx[23:8]}, {8'h0, e});
    endtask

    task automatic t_burn();
        wr(ADDR_FUSE, 8'h10);
        check("burns", burns[23:0], 24'h1);
        check("burn addr", {20'h0, baddr}, {20'h0, ADDR_ZOFS_HI});
        check("burn data", {16'h0, bdata}, 24'h23);
        wr(ADDR_ZOFS_HI, 8'h55);
        rd(ADDR_ZOFS_HI, 8'h23);
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        zofs = 12'h230;
        setraw(raw);
        rd(ADDR_ZOFS_HI, 8'h23);
        rd(ADDR_ZOFS_LO, 8'h00);
    endtask

    // ****************
    // Main sequence and watchdog
    // ****************
    initial
    begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_regs();
        t_offset();
        t_short();
        t_index();
        t_freeze();
        t_burn();
        test_done();
    end

    // All scenarios need well under 12000 cycles; a hang stops here
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        test_done();
    end
endmodule

`default_nettype wire
